// File: src/csf_pkg.sv
// Constants, field positions and carriers for the compute status flags.
// Assumes one core clock, an active-low asynchronous reset and result
// summaries from the compute units that are valid for one cycle each.
package csf_pkg;

  // ==========================================================================
  // Register map, byte addresses on the register port.
  localparam logic [7:0] CSF_OFS_PRI_ARITH  = 8'h00;
  localparam logic [7:0] CSF_OFS_SEC_ARITH  = 8'h04;
  localparam logic [7:0] CSF_OFS_PRI_STICKY = 8'h08;
  localparam logic [7:0] CSF_OFS_SEC_STICKY = 8'h0C;

  // ==========================================================================
  // Arithmetic status bit positions.
  localparam int CSF_A_ZERO  = 0;
  localparam int CSF_A_OVF   = 1;
  localparam int CSF_A_NEG   = 2;
  localparam int CSF_A_CARRY = 3;
  localparam int CSF_A_XSIGN = 4;
  localparam int CSF_A_INV   = 5;
  localparam int CSF_M_NEG   = 6;
  localparam int CSF_M_OVF   = 7;
  localparam int CSF_M_UNF   = 8;
  localparam int CSF_M_INV   = 9;
  localparam int CSF_A_FLT   = 10;
  localparam int CSF_S_OVF   = 11;
  localparam int CSF_S_ZERO  = 12;

  // ==========================================================================
  // Sticky status bit positions.
  localparam int CSF_A_UNF_HELD  = 0;
  localparam int CSF_A_FOVF_HELD = 1;
  localparam int CSF_A_XOVF_HELD = 2;
  localparam int CSF_A_INV_HELD  = 5;
  localparam int CSF_M_XOVF_HELD = 6;
  localparam int CSF_M_FOVF_HELD = 7;
  localparam int CSF_M_UNF_HELD  = 8;
  localparam int CSF_M_INV_HELD  = 9;
  localparam int CSF_STK_LSB     = 21;
  localparam int CSF_STK_MSB     = 26;

  // ==========================================================================
  // Writable masks and values after reset.
  localparam logic [31:0] CSF_ARITH_MASK  = 32'h0000_1FFF;
  localparam logic [31:0] CSF_STICKY_MASK = 32'h0000_03E7;
  localparam logic [31:0] CSF_ARITH_RST   = 32'h0000_0000;
  localparam logic [31:0] CSF_STICKY_RST  = 32'h0000_0000;
  localparam logic [79:0] CSF_ACC_RST     = 80'h0;

  // ==========================================================================
  // Limits: exponents are unbiased, signed, ten bits wide.
  localparam logic signed [9:0] CSF_EXP_MAX   = 10'sh07F;
  localparam logic signed [9:0] CSF_EXP_MIN   = 10'sh382;
  localparam logic [7:0]        CSF_FIELD_W   = 8'h20;
  localparam logic [5:0]        CSF_LEAD_FULL = 6'h20;
  localparam int CSF_SFRAC_TOP = 17;
  localparam int CSF_SINT_TOP  = 49;
  localparam int CSF_UFRAC_TOP = 16;
  localparam int CSF_UINT_TOP  = 48;
  localparam int CSF_UNF_TOP   = 48;

  // ==========================================================================
  // Carriers from the compute units, one per lane and cycle.
  typedef struct packed {
    logic              valid;
    logic              is_float;
    logic              sat_mode;
    logic              is_add;
    logic              is_sub;
    logic              is_f2x;
    logic              f2x_ovf;
    logic              a_nan;
    logic              b_nan;
    logic              a_inf;
    logic              b_inf;
    logic              a_sign;
    logic              b_sign;
    logic              abs_mant;
    logic              x_sign;
    logic [1:0]        res_msb2;
    logic              res_zero;
    logic              res_neg;
    logic              carry;
    logic              fp_tiny;
    logic signed [9:0] exp_unb;
  } csf_alu_op_t;

  typedef struct packed {
    logic              valid;
    logic              is_float;
    logic              is_signed;
    logic              is_frac;
    logic              to_acc;
    logic              a_nan;
    logic              b_nan;
    logic              a_inf;
    logic              b_inf;
    logic              a_zero;
    logic              b_zero;
    logic              a_denorm;
    logic              b_denorm;
    logic              res_neg;
    logic signed [9:0] exp_unb;
    logic [79:0]       acc;
  } csf_mpy_op_t;

  typedef struct packed {
    logic       valid;
    logic       res_zero;
    logic       shl_lost;
    logic       bit_op;
    logic       bit_test;
    logic [7:0] bit_pos;
    logic       extract;
    logic [7:0] ext_end;
    logic       lead_count;
    logic [5:0] lead_result;
  } csf_shf_op_t;

  // Whole state of the block, registered as one word.
  typedef struct packed {
    logic [1:0][31:0] arith;
    logic [1:0][31:0] sticky;
    logic [1:0][79:0] acc;
    logic [31:0]      rdata;
  } csf_state_t;

endpackage

// File: src/csf_status_flags.sv
// Status flag logic for both processing lanes: arithmetic status,
// sticky status and the multiplier result accumulator words.
// Assumes the compute units present one summary per lane per cycle and
// software reaches the registers over a simple strobe port.
//
// The register offsets and strobed register access were decided locally.
module csf_status_flags
  import csf_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire csf_alu_op_t      alu_op [2],
  input  wire csf_mpy_op_t      mpy_op [2],
  input  wire csf_shf_op_t      shf_op [2],
  input  wire logic [5:0]       stack_status,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [31:0]           reg_rdata,
  output logic [1:0][31:0]      arith_status,
  output logic [1:0][31:0]      sticky_status,
  output logic [1:0][31:0]      acc_low_word,
  output logic [1:0][31:0]      acc_mid_word,
  output logic [1:0][15:0]      acc_high_word
);

  // ==========================================================================
  // Helper functions

  // True when the top n bits of the accumulator all equal its sign bit.
  function automatic logic top_uniform(input logic [79:0] a, input int n);
    logic r;
    r = 1'b1;
    for (int i = 0; i < 80; i++)
    begin
      if (i >= 80 - n && a[i] != a[79])
        r = 1'b0;
    end
    return r;
  endfunction

  // True when the top n bits of the accumulator are all zero.
  function automatic logic top_zero(input logic [79:0] a, input int n);
    logic r;
    r = 1'b1;
    for (int i = 0; i < 80; i++)
    begin
      if (i >= 80 - n && a[i])
        r = 1'b0;
    end
    return r;
  endfunction

  // ==========================================================================
  // State

  csf_state_t st;
  csf_state_t next_st;

  // ==========================================================================
  // Next-state logic. Software effects are applied first so that the
  // hardware updates of the same cycle overlay them.
  always_comb
  begin
    logic alu_inv;
    logic alu_fix_ovf;
    logic alu_flt_ovf;
    logic alu_unf;
    logic mpy_flt_ovf;
    logic mpy_fix_ovf;
    logic mpy_flt_unf;
    logic mpy_fix_unf;
    logic mpy_inv;
    logic op_zero_a;
    logic op_zero_b;
    logic shf_outside;
    logic shf_ovf;
    alu_inv     = 1'b0;
    alu_fix_ovf = 1'b0;
    alu_flt_ovf = 1'b0;
    alu_unf     = 1'b0;
    mpy_flt_ovf = 1'b0;
    mpy_fix_ovf = 1'b0;
    mpy_flt_unf = 1'b0;
    mpy_fix_unf = 1'b0;
    mpy_inv     = 1'b0;
    op_zero_a   = 1'b0;
    op_zero_b   = 1'b0;
    shf_outside = 1'b0;
    shf_ovf     = 1'b0;
    next_st       = st;
    next_st.rdata = '0;

    // Register reads answer in the next cycle only; unmapped reads are zero.
    if (reg_rd)
    begin
      case (reg_addr)
        CSF_OFS_PRI_ARITH:  next_st.rdata = st.arith[0];
        CSF_OFS_SEC_ARITH:  next_st.rdata = st.arith[1];
        CSF_OFS_PRI_STICKY: next_st.rdata = st.sticky[0];
        CSF_OFS_SEC_STICKY: next_st.rdata = st.sticky[1];
        default:            next_st.rdata = '0;
      endcase
    end

    // Software writes load the writable bits; this is also how interrupt
    // software clears a sticky bit to catch the next occurrence.
    if (reg_wr)
    begin
      case (reg_addr)
        CSF_OFS_PRI_ARITH:  next_st.arith[0] = reg_wdata & CSF_ARITH_MASK;
        CSF_OFS_SEC_ARITH:  next_st.arith[1] = reg_wdata & CSF_ARITH_MASK;
        CSF_OFS_PRI_STICKY: next_st.sticky[0] = reg_wdata & CSF_STICKY_MASK;
        CSF_OFS_SEC_STICKY: next_st.sticky[1] = reg_wdata & CSF_STICKY_MASK;
        default:            next_st.rdata = next_st.rdata;
      endcase
    end

    // Each lane has its own pair of registers and its own compute events.
    for (int l = 0; l < 2; l++)
    begin
      // ALU events: flags are rewritten, stickies only ever set.
      if (alu_op[l].valid)
      begin
        alu_inv = alu_op[l].a_nan || alu_op[l].b_nan
          || (alu_op[l].is_add && alu_op[l].a_inf && alu_op[l].b_inf
              && (alu_op[l].a_sign != alu_op[l].b_sign))
          || (alu_op[l].is_sub && alu_op[l].a_inf && alu_op[l].b_inf
              && (alu_op[l].a_sign == alu_op[l].b_sign))
          || (alu_op[l].is_f2x && !alu_op[l].sat_mode
              && (alu_op[l].f2x_ovf || alu_op[l].a_inf));
        alu_fix_ovf = !alu_op[l].is_float
          && (alu_op[l].res_msb2[1] ^ alu_op[l].res_msb2[0]);
        alu_flt_ovf = alu_op[l].is_float
          && (alu_op[l].exp_unb > CSF_EXP_MAX);
        alu_unf = alu_op[l].is_float && alu_op[l].fp_tiny;
        next_st.arith[l][CSF_A_ZERO] = alu_op[l].res_zero
          || alu_unf;
        next_st.arith[l][CSF_A_OVF] = alu_fix_ovf || alu_flt_ovf;
        next_st.arith[l][CSF_A_NEG] = alu_op[l].res_neg;
        next_st.arith[l][CSF_A_CARRY] = !alu_op[l].is_float && alu_op[l].carry;
        next_st.arith[l][CSF_A_XSIGN] = alu_op[l].abs_mant && alu_op[l].x_sign;
        next_st.arith[l][CSF_A_INV] = alu_inv;
        next_st.arith[l][CSF_A_FLT] = alu_op[l].is_float;
        if (alu_unf)
          next_st.sticky[l][CSF_A_UNF_HELD] = 1'b1;
        if (alu_flt_ovf)
          next_st.sticky[l][CSF_A_FOVF_HELD] = 1'b1;
        if (alu_fix_ovf)
          next_st.sticky[l][CSF_A_XOVF_HELD] = 1'b1;
        if (alu_inv)
          next_st.sticky[l][CSF_A_INV_HELD] = 1'b1;
      end

      // Multiplier events.
      if (mpy_op[l].valid)
      begin
        // Cleared per lane, so one lane's result never leaks into the other.
        mpy_flt_ovf = 1'b0;
        mpy_fix_ovf = 1'b0;
        mpy_flt_unf = 1'b0;
        mpy_fix_unf = 1'b0;
        mpy_inv     = 1'b0;
        // Denormal operands behave as zeros, so they cannot underflow.
        op_zero_a = mpy_op[l].a_zero || mpy_op[l].a_denorm;
        op_zero_b = mpy_op[l].b_zero || mpy_op[l].b_denorm;
        if (mpy_op[l].is_float)
        begin
          mpy_flt_ovf = mpy_op[l].exp_unb > CSF_EXP_MAX;
          mpy_flt_unf = !op_zero_a && !op_zero_b
            && (mpy_op[l].exp_unb < CSF_EXP_MIN);
          mpy_inv = mpy_op[l].a_nan || mpy_op[l].b_nan
            || (mpy_op[l].a_inf && op_zero_b)
            || (op_zero_a && mpy_op[l].b_inf);
          next_st.arith[l][CSF_M_INV] = mpy_inv;
        end
        else
        begin
          if (mpy_op[l].is_signed)
            mpy_fix_ovf = mpy_op[l].is_frac
              ? !top_uniform(mpy_op[l].acc, CSF_SFRAC_TOP)
              : !top_uniform(mpy_op[l].acc, CSF_SINT_TOP);
          else
            mpy_fix_ovf = mpy_op[l].is_frac
              ? !top_zero(mpy_op[l].acc, CSF_UFRAC_TOP)
              : !top_zero(mpy_op[l].acc, CSF_UINT_TOP);
          // Integer results have no fractional bits and never underflow.
          mpy_fix_unf = mpy_op[l].is_frac && (|mpy_op[l].acc[31:0])
            && (mpy_op[l].is_signed
                ? top_uniform(mpy_op[l].acc, CSF_UNF_TOP)
                : top_zero(mpy_op[l].acc, CSF_UNF_TOP));
          // The full 80-bit result is kept, so overflow bits stay in the
          // mid and high words and underflow bits in the low word.
          if (mpy_op[l].to_acc)
            next_st.acc[l] = mpy_op[l].acc;
        end
        next_st.arith[l][CSF_M_NEG] = mpy_op[l].res_neg;
        next_st.arith[l][CSF_M_OVF] = mpy_flt_ovf || mpy_fix_ovf;
        next_st.arith[l][CSF_M_UNF] = mpy_flt_unf || mpy_fix_unf;
        if (mpy_fix_ovf)
          next_st.sticky[l][CSF_M_XOVF_HELD] = 1'b1;
        if (mpy_flt_ovf)
          next_st.sticky[l][CSF_M_FOVF_HELD] = 1'b1;
        if (mpy_flt_unf || mpy_fix_unf)
          next_st.sticky[l][CSF_M_UNF_HELD] = 1'b1;
        if (mpy_inv)
          next_st.sticky[l][CSF_M_INV_HELD] = 1'b1;
      end

      // Shifter events; there is no shifter sticky bit.
      if (shf_op[l].valid)
      begin
        // A bit test is a bit operation even when bit_op is not raised.
        shf_outside = (shf_op[l].bit_op || shf_op[l].bit_test)
          && (shf_op[l].bit_pos >= CSF_FIELD_W);
        shf_ovf = shf_op[l].shl_lost || shf_outside
          || (shf_op[l].extract && (shf_op[l].ext_end > CSF_FIELD_W))
          || (shf_op[l].lead_count
              && (shf_op[l].lead_result == CSF_LEAD_FULL));
        next_st.arith[l][CSF_S_OVF] = shf_ovf;
        next_st.arith[l][CSF_S_ZERO] = shf_op[l].res_zero
          || (shf_outside && shf_op[l].bit_test);
      end
    end

    // Stack status is read-only and only the primary lane carries it.
    next_st.sticky[0][CSF_STK_MSB:CSF_STK_LSB] = stack_status;
    next_st.sticky[1][CSF_STK_MSB:CSF_STK_LSB] = '0;
  end

  // ==========================================================================
  // State register. Stickies are held here until software clears them.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st.arith  <= {CSF_ARITH_RST, CSF_ARITH_RST};
      st.sticky <= {CSF_STICKY_RST, CSF_STICKY_RST};
      st.acc    <= {CSF_ACC_RST, CSF_ACC_RST};
      st.rdata  <= '0;
    end
    else
      st <= next_st;
  end

  // ==========================================================================
  // Outputs, all taken straight from the state register.
  assign reg_rdata     = st.rdata;
  assign arith_status  = st.arith;
  assign sticky_status = st.sticky;

  // Split of the 80-bit accumulator into its three words.
  always_comb
  begin
    for (int l = 0; l < 2; l++)
    begin
      acc_low_word[l]  = st.acc[l][31:0];
      acc_mid_word[l]  = st.acc[l][63:32];
      acc_high_word[l] = st.acc[l][79:64];
    end
  end

endmodule

// File: testbench/csf_status_flags_props.sv
// Concurrent checks on the ports of the status flag block.
// Assumes the core clock and active-low reset of the design.
module csf_status_flags_props
  import csf_pkg::*;
(
  input wire logic             core_clk,
  input wire logic             arst_n,
  input wire csf_alu_op_t      alu_op [2],
  input wire csf_mpy_op_t      mpy_op [2],
  input wire csf_shf_op_t      shf_op [2],
  input wire logic [7:0]       reg_addr,
  input wire logic             reg_wr,
  input wire logic [1:0][31:0] arith_status,
  input wire logic [1:0][31:0] sticky_status
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====================
  // Primary lane shorthands; a flag answers one cycle after its cause.
  wire csf_alu_op_t a0 = alu_op[0];
  wire csf_mpy_op_t m0 = mpy_op[0];
  wire csf_shf_op_t s0 = shf_op[0];
  wire logic [31:0] as0 = arith_status[0];
  wire logic [31:0] ss0 = sticky_status[0];
  wire logic        fx = m0.valid && !m0.is_float;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  a_alu_invalid_set:
  assert property (a0.valid && (a0.a_nan || a0.b_nan)
    |=> as0[CSF_A_INV] && ss0[CSF_A_INV_HELD])
    else $error("alu invalid not set");
  a_alu_float_kind:
  assert property (a0.valid |=> as0[CSF_A_FLT] == $past(a0.is_float))
    else $error("alu float kind wrong");
  a_mpy_sign_flag:
  assert property (m0.valid |=> as0[CSF_M_NEG] == $past(m0.res_neg))
    else $error("multiplier sign flag wrong");
  a_sfrac_ovf_set:
  assert property (fx && m0.is_signed && m0.is_frac && |m0.acc[79:63]
    && !(&m0.acc[79:63]) |=> as0[CSF_M_OVF] && ss0[CSF_M_XOVF_HELD])
    else $error("signed fraction overflow missed");
  a_uint_ovf_set:
  assert property (fx && !m0.is_signed && !m0.is_frac && |m0.acc[79:32]
    |=> as0[CSF_M_OVF] && ss0[CSF_M_XOVF_HELD])
    else $error("unsigned overflow missed");
  a_mpy_inv_kept:
  assert property (fx && !(reg_wr && reg_addr == CSF_OFS_PRI_ARITH)
    |=> $stable(as0[CSF_M_INV])) else $error("fixed multiply moved invalid");
  a_lead_full_ovf:
  assert property (s0.valid && s0.lead_count && s0.lead_result == 6'h20
    |=> as0[CSF_S_OVF]) else $error("full lead count not flagged");
  a_shift_zero_set:
  assert property (s0.valid && (s0.res_zero || s0.bit_test
    && s0.bit_pos >= CSF_FIELD_W) |=> as0[CSF_S_ZERO])
    else $error("shifter zero not set");
  a_sticky_holds:
  assert property (ss0[CSF_A_INV_HELD]
    && !(reg_wr && reg_addr == CSF_OFS_PRI_STICKY)
    |=> ss0[CSF_A_INV_HELD]) else $error("sticky bit dropped");
endmodule

bind csf_status_flags csf_status_flags_props i_csf_status_flags_props (
  .core_clk(core_clk), .arst_n(arst_n), .alu_op(alu_op), .mpy_op(mpy_op),
  .shf_op(shf_op), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .arith_status(arith_status), .sticky_status(sticky_status)
);

// File: testbench/csf_unit_model.sv
// Stand-in for the ALU, multiplier and shifter of both lanes.
// Assumes one caller per lane and unit at a time.
module csf_unit_model
  import csf_pkg::*;
(
  input  wire logic  core_clk,
  output csf_alu_op_t alu_op [2],
  output csf_mpy_op_t mpy_op [2],
  output csf_shf_op_t shf_op [2]
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====================
  // Idle summaries. Only valid drops after an operation; the result
  // fields stay standing, as a real unit leaves its buses.
  initial
  begin
    alu_op = '{default: '0};
    mpy_op = '{default: '0};
    shf_op = '{default: '0};
  end

  // Each summary stands valid for exactly one cycle.
  task automatic alu(input int ln, input csf_alu_op_t op);
    @(posedge core_clk);
    op.valid = 1'b1;
    alu_op[ln] <= op;
    @(posedge core_clk);
    alu_op[ln].valid <= 1'b0;
    #1;
  endtask

  task automatic mpy(input int ln, input csf_mpy_op_t op);
    @(posedge core_clk);
    op.valid = 1'b1;
    mpy_op[ln] <= op;
    @(posedge core_clk);
    mpy_op[ln].valid <= 1'b0;
    #1;
  endtask

  task automatic shf(input int ln, input csf_shf_op_t op);
    @(posedge core_clk);
    op.valid = 1'b1;
    shf_op[ln] <= op;
    @(posedge core_clk);
    shf_op[ln].valid <= 1'b0;
    #1;
  endtask
endmodule

// File: testbench/csf_status_flags_tb.sv
// Self-checking bench for the status flag block.
// Assumes the unit model drives the compute summaries.
module csf_status_flags_tb
  import csf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ====================
  // Stimulus, observation and tables of cases.
  logic             core_clk = 1'b0;
  logic             arst_n = 1'b0;
  logic [5:0]       stack_status = 6'h00;
  logic [7:0]       reg_addr = 8'h00;
  logic [31:0]      reg_wdata = 32'h0000_0000;
  logic             reg_wr = 1'b0;
  logic             reg_rd = 1'b0;
  logic [31:0]      reg_rdata;
  logic [1:0][31:0] arith_status;
  logic [1:0][31:0] sticky_status;
  logic [1:0][31:0] acc_low_word;
  logic [1:0][31:0] acc_mid_word;
  logic [1:0][15:0] acc_high_word;
  csf_alu_op_t      alu_op [2];
  csf_mpy_op_t      mpy_op [2];
  csf_shf_op_t      shf_op [2];
  csf_mpy_op_t      o;
  logic [31:0]      d;
  logic [31:0]      e;
  int               fail_count = 0;
  int               checked = 0;
  csf_alu_op_t      ac [6] = '{'{is_float: 1, a_nan: 1, default: '0},
    '{is_float: 1, is_add: 1, a_inf: 1, b_inf: 1, b_sign: 1, default: '0},
    '{is_float: 1, is_sub: 1, a_inf: 1, b_inf: 1, default: '0},
    '{is_float: 1, is_f2x: 1, f2x_ovf: 1, default: '0},
    '{is_float: 1, is_f2x: 1, a_inf: 1, default: '0},
    '{is_float: 1, is_f2x: 1, f2x_ovf: 1, sat_mode: 1, default: '0}};
  csf_mpy_op_t      mc [11] = '{'{is_float: 1, a_inf: 1, b_zero: 1, default: '0},
    '{is_signed: 1, is_frac: 1, acc: 80'h0012_8000_0001_0000_0003, default: '0},
    '{is_signed: 1, is_frac: 1, acc: 80'hFFFF_FFFF_FFFF_8000_0000, default: '0},
    '{is_signed: 1, acc: 80'h0000_0000_0000_8000_0000, default: '0},
    '{acc: 80'h0000_0000_0001_0000_0000, default: '0},
    '{is_frac: 1, acc: 80'h0000_0000_0001_0000_0000, default: '0},
    '{is_frac: 1, acc: 80'h0000_0000_0000_0000_0001, default: '0},
    '{is_float: 1, exp_unb: 10'sd128, default: '0},
    '{is_float: 1, exp_unb: 10'sd127, default: '0},
    '{is_float: 1, exp_unb: -10'sd127, default: '0},
    '{is_float: 1, exp_unb: -10'sd127, a_denorm: 1, default: '0}};
  logic [6:0]       me [11] = '{7'h48, 7'h51, 7'h64, 7'h51, 7'h51, 7'h40,
    7'h64, 7'h12, 7'h00, 7'h24, 7'h00};
  csf_shf_op_t      sc [4] = '{'{bit_test: 1, bit_pos: 8'h20, default: '0},
    '{lead_count: 1, lead_result: 6'h20, default: '0},
    '{extract: 1, ext_end: 8'h21, default: '0}, '{res_zero: 1, default: '0}};
  logic [1:0]       se [4] = '{2'b11, 2'b01, 2'b01, 2'b10};

`define CHK(nm, ex, g) \
  begin \
    checked++; \
    if ((g) !== (ex)) \
    begin \
      fail_count++; \
      $display("mismatch %s expected %0h seen %0h", nm, ex, g); \
    end \
  end

  // Clock, the unit under test and its far side.
  always #50 core_clk = ~core_clk;
  csf_status_flags i_csf_status_flags (.core_clk(core_clk), .arst_n(arst_n),
    .alu_op(alu_op), .mpy_op(mpy_op), .shf_op(shf_op),
    .stack_status(stack_status), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .arith_status(arith_status), .sticky_status(sticky_status),
    .acc_low_word(acc_low_word), .acc_mid_word(acc_mid_word),
    .acc_high_word(acc_high_word));
  csf_unit_model i_csf_unit_model (.core_clk(core_clk), .alu_op(alu_op),
    .mpy_op(mpy_op), .shf_op(shf_op));

  // Register port: one-cycle strobes, read data in the following cycle.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic close_out;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // A run needs well under a thousand cycles, so this only cuts hangs.
  initial
  begin
    #2000000;
    fail_count++;
    close_out();
  end

  // Main sequence of tests.
  initial
  begin
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      e = i < 2 ? CSF_ARITH_MASK : i < 4 ? CSF_STICKY_MASK : 32'h0;
      rd(8'(4 * i), d);
      `CHK("reset value", 32'h0000_0000, d)
      wr(8'(4 * i), 32'hFFFF_FFFF);
      rd(8'(4 * i), d);
      `CHK("written value", e, d)
      wr(8'(4 * i), 32'h0000_0000);
    end
    $display("registers done");
    for (int i = 0; i < 6; i++)
    begin
      wr(CSF_OFS_PRI_STICKY, 32'h0000_0000);
      i_csf_unit_model.alu(0, ac[i]);
      `CHK("alu invalid", i < 5, arith_status[0][CSF_A_INV])
      `CHK("alu sticky", i < 5, sticky_status[0][CSF_A_INV_HELD])
    end
    wr(CSF_OFS_PRI_STICKY, 32'h0000_0000);
    i_csf_unit_model.alu(0, '{res_msb2: 2'b01, default: '0});
    i_csf_unit_model.alu(0, '{is_float: 1, exp_unb: 10'sd128, default: '0});
    i_csf_unit_model.alu(0, '{is_float: 1, fp_tiny: 1, default: '0});
    `CHK("alu tiny", 2'b01, arith_status[0][1:0])
    `CHK("sticky byte", 8'h07, sticky_status[0][7:0])
    i_csf_unit_model.alu(0, '{res_msb2: 2'b11, default: '0});
    `CHK("flags follow", 2'b00, arith_status[0][1:0])
    `CHK("float kind", 1'b0, arith_status[0][CSF_A_FLT])
    `CHK("sticky kept", 8'h07, sticky_status[0][7:0])
    $display("alu done");
    for (int i = 0; i < 11; i++)
    begin
      o = mc[i];
      o.res_neg = i[0];
      o.to_acc = 1'b1;
      wr(CSF_OFS_PRI_STICKY, 32'h0000_0000);
      i_csf_unit_model.mpy(0, o);
      `CHK("mpy flags", me[i][6:4], arith_status[0][9:7])
      `CHK("mpy sticky", me[i][3:0], sticky_status[0][9:6])
      `CHK("mpy negative", i[0], arith_status[0][CSF_M_NEG])
      if (!o.is_float)
        `CHK("acc words", o.acc, {acc_high_word[0], acc_mid_word[0],
          acc_low_word[0]})
    end
    for (int i = 0; i < 4; i++)
    begin
      i_csf_unit_model.shf(0, sc[i]);
      `CHK("shift flags", se[i], arith_status[0][12:11])
    end
    $display("multiplier and shifter done");
    stack_status <= 6'h2A;
    i_csf_unit_model.alu(1, ac[0]);
    `CHK("lane sticky", 32'h0000_0020, sticky_status[1])
    `CHK("stack mirror", 6'h2A, sticky_status[0][26:21])
    fork
      i_csf_unit_model.mpy(1, mc[1]);
      wr(CSF_OFS_SEC_STICKY, 32'h0000_0000);
    join
    rd(CSF_OFS_SEC_STICKY, d);
    `CHK("set beats clear", 32'h0000_0040, d)
    `CHK("lane flags", 32'h0000_04A0, arith_status[1])
    `CHK("acc kept", 80'h0, {acc_high_word[1], acc_mid_word[1],
      acc_low_word[1]})
    // A fixed overflow on the primary lane must not reach the secondary.
    fork
      i_csf_unit_model.mpy(0, mc[1]);
      i_csf_unit_model.mpy(1, mc[8]);
    join
    `CHK("lanes apart", 3'b000, arith_status[1][9:7])
    $display("lanes done");
    close_out();
  end
endmodule
